// File: hw/pmcb_bank.sv
// Purpose: Command-addressed register bank of a two-channel controller
// Assumes: Host frames whole bytes; frame end runs the command
// Notes: Reads answer in the first sixteen bits of the next frame
//
// Behaviour
// - Byte at 0x00 selects the channel for paged commands, resets 0x00
// - Paged byte 0x01 sets run and margin, default 0x80
// - Paged stored byte 0x02 sets turn-on sources, default 0x1E
// - Send-byte 0x03 clears every set fault flag except those of still-active fault pins
// - Block write 0x05 applies an embedded command to a named page
// - Process call 0x06 returns an embedded read from a named page
// - Stored byte 0x10 guards against unwanted writes, default 0x00
// - Send-byte 0x15 copies all operating settings into stored image
// - Send-byte 0x16 reloads all operating settings from stored image while guard bits 7..5 are clear
// - Read-only byte 0x19 always returns 0xB0
// - Paged linear word 0x27 sets output slew, default 0xAA00
// - Linear word 0x35 sets input start level, default 0xCB40
// - Linear word 0x36 sets input stop level, default 0xCB00
// - Paged read-only byte 0x41 reads overvoltage reaction 0x80
// - Paged linear word 0x46 sets overcurrent fault level 0xDBB8
// - Paged byte 0x47 selects overcurrent reaction, default 0x00
// - Paged linear word 0x4A sets overcurrent warning level 0xDA80
// - Paged linear word 0x4F sets overheat fault level 0xEB20
// - Paged byte 0x50 selects overheat reaction, default 0xB8
// - Paged linear word 0x51 sets overheat warning level 0xEAA8
// - Linear words: signed exponent bits 15..11, signed mantissa 10..0

`timescale 1ns/1ps

module pmcb_bank
  import pmcb_pkg::*;
(
  // Core clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Serial link from the host
  input wire logic link_clk_in,
  input wire logic link_sel_in,
  input wire logic link_sdi_in,
  output logic link_sdo_out,
  // Fault inputs from the power stages
  input wire logic [NCH-1:0] fault_oc_in,
  input wire logic [NCH-1:0] fault_ot_in,
  // Control and status
  output logic [NCH-1:0] run_cmd_out,
  output logic [7:0] fault_flags_out
);

  typedef struct packed {
    pmcb_cfg_t cfg;
    pmcb_cfg_t nvm;
    logic [7:0] page;
    logic [2:0] nb;
    logic [5:0][7:0] fb;
    logic par_d;
    logic ack;
    logic sel_q;
    logic [15:0] resp;
    logic [7:0] flags;
    logic [NCH-1:0] run;
  } pmcb_core_t;

  pmcb_core_t st_r;
  pmcb_core_t st_nxt;

  logic lnk_clr_n;
  logic [7:0] lnk_byte;
  logic lnk_par;
  logic [2*NCH+1:0] sync_q;
  logic sel_s;
  logic par_s;
  logic exec;

  // Classify a code as byte, word, send-only, read-only or unknown
  function automatic logic [2:0] cmd_kind(input logic [7:0] c);
    case (c)
      CMD_PAGE, CMD_OPER, CMD_ONOFF, CMD_GUARD, CMD_AMASK, CMD_UVR,
      CMD_OCR, CMD_OTR: cmd_kind = KIND_BYTE;
      CMD_SLEW, CMD_FSW, CMD_VINON, CMD_VINOFF, CMD_GAIN, CMD_OCLIM,
      CMD_OCWARN, CMD_OTLIM, CMD_OTWARN: cmd_kind = KIND_WORD;
      CMD_CLEAR, CMD_STORE, CMD_RESTORE: cmd_kind = KIND_SEND;
      CMD_FEAT, CMD_OVR: cmd_kind = KIND_ROB;
      default: cmd_kind = KIND_NONE;
    endcase
  endfunction

  // Guard level decides which codes still accept writes
  function automatic logic wr_ok(input logic [7:0] c, input logic [7:0] g);
    if (c == CMD_GUARD) begin
      wr_ok = 1'b1;
    end else if (g[GUARD_ALL_BIT]) begin
      wr_ok = 1'b0;
    end else if (g[GUARD_OPS_BIT]) begin
      wr_ok = (c == CMD_PAGE) || (c == CMD_OPER);
    end else if (g[GUARD_CFG_BIT]) begin
      wr_ok = (c == CMD_PAGE) || (c == CMD_OPER) || (c == CMD_ONOFF);
    end else begin
      wr_ok = 1'b1;
    end
  endfunction

  // Read one command from a channel copy; bytes sit in the low lane
  function automatic logic [15:0] rd_reg(input pmcb_cfg_t c,
                                         input logic [7:0] cmd,
                                         input logic [7:0] pg,
                                         input logic [7:0] sel);
    logic ch;
    ch = (pg == ALL_PAGES) ? 1'b0 : pg[0];
    case (cmd)
      CMD_PAGE: rd_reg = {8'h00, sel};
      CMD_OPER: rd_reg = {8'h00, c.oper[ch]};
      CMD_ONOFF: rd_reg = {8'h00, c.onoff[ch]};
      CMD_GUARD: rd_reg = {8'h00, c.guard};
      CMD_FEAT: rd_reg = {8'h00, FEAT_VAL};
      CMD_AMASK: rd_reg = {8'h00, c.amask[ch]};
      CMD_SLEW: rd_reg = c.slew[ch];
      CMD_FSW: rd_reg = c.fsw;
      CMD_VINON: rd_reg = c.vinon;
      CMD_VINOFF: rd_reg = c.vinoff;
      CMD_GAIN: rd_reg = c.gain[ch];
      CMD_OVR: rd_reg = {8'h00, OVR_VAL};
      CMD_UVR: rd_reg = {8'h00, c.uvr[ch]};
      CMD_OCLIM: rd_reg = c.oclim[ch];
      CMD_OCR: rd_reg = {8'h00, c.ocr[ch]};
      CMD_OCWARN: rd_reg = c.ocwarn[ch];
      CMD_OTLIM: rd_reg = c.otlim[ch];
      CMD_OTR: rd_reg = {8'h00, c.otr[ch]};
      CMD_OTWARN: rd_reg = c.otwarn[ch];
      default: rd_reg = 16'h0000;
    endcase
  endfunction

  // Write one command into every channel copy that the page names
  function automatic pmcb_cfg_t wr_reg(input pmcb_cfg_t c,
                                       input logic [7:0] cmd,
                                       input logic [7:0] pg,
                                       input logic [15:0] w);
    pmcb_cfg_t r;
    r = c;
    for (int i = 0; i < NCH; i++) begin
      if ((pg == ALL_PAGES) || (pg[0] == i[0])) begin
        case (cmd)
          CMD_OPER: r.oper[i] = w[7:0];
          CMD_ONOFF: r.onoff[i] = w[7:0];
          CMD_AMASK: r.amask[i] = w[7:0];
          CMD_SLEW: r.slew[i] = w;
          CMD_GAIN: r.gain[i] = w;
          CMD_UVR: r.uvr[i] = w[7:0];
          CMD_OCLIM: r.oclim[i] = w;
          CMD_OCR: r.ocr[i] = w[7:0];
          CMD_OCWARN: r.ocwarn[i] = w;
          CMD_OTLIM: r.otlim[i] = w;
          CMD_OTR: r.otr[i] = w[7:0];
          CMD_OTWARN: r.otwarn[i] = w;
          default: r.oper[i] = r.oper[i];
        endcase
      end
    end
    case (cmd)
      CMD_GUARD: r.guard = w[7:0];
      CMD_FSW: r.fsw = w;
      CMD_VINON: r.vinon = w;
      CMD_VINOFF: r.vinoff = w;
      default: r.guard = r.guard;
    endcase
    return r;
  endfunction

  // Frame select clears the shifter so every frame starts at bit zero
  assign lnk_clr_n = nrst_in & link_sel_in;

  pmcb_link u_link (
    .link_clk_in(link_clk_in),
    .clr_n_in(lnk_clr_n),
    .sdi_in(link_sdi_in),
    .resp_in(st_r.resp),
    .byte_out(lnk_byte),
    .par_out(lnk_par),
    .sdo_out(link_sdo_out)
  );

  // Frame select, byte parity and fault pins all cross on two flops
  pmcb_sync #(.W(2*NCH+2)) u_sync (
    .clk_in(clock_in),
    .nrst_in(nrst_in),
    .d_in({fault_ot_in, fault_oc_in, lnk_par, link_sel_in}),
    .q_out(sync_q)
  );

  assign sel_s = sync_q[0];
  assign par_s = sync_q[1];
  // Frame end runs the collected command once
  assign exec = st_r.sel_q & ~sel_s;

  // Collect frame bytes, decode at frame end, update flags and outputs
  always_comb begin
    logic pp;
    logic [2:0] k;
    logic [7:0] b0;
    logic [7:0] ec;
    logic [7:0] tp;
    logic [2:0] kind;
    logic [15:0] w;
    logic need2;
    logic cml;
    logic clr;
    logic [7:0] set_v;
    st_nxt = st_r;
    cml = 1'b0;
    clr = 1'b0;
    set_v = 8'h00;
    set_v[FLT_OC_LSB +: NCH] = sync_q[2 +: NCH];
    set_v[FLT_OT_LSB +: NCH] = sync_q[2+NCH +: NCH];
    st_nxt.sel_q = sel_s;
    // One extra stage keeps byte events behind the frame-end view
    st_nxt.par_d = par_s;
    b0 = st_r.fb[0];
    pp = (b0 == CMD_PPW) || (b0 == CMD_PPR);
    k = pp ? PP_HDR : 3'h0;
    ec = st_r.fb[k];
    tp = pp ? st_r.fb[PP_PAGE_IDX] : st_r.page;
    kind = cmd_kind(ec);
    w = {st_r.fb[k+3'h2], st_r.fb[k+3'h1]}; // Lo byte first
    need2 = (kind == KIND_WORD);
    if (sel_s && (st_r.par_d != st_r.ack)) begin
      st_nxt.ack = st_r.par_d;
      if (st_r.nb < MAX_BYTES) begin
        st_nxt.fb[st_r.nb] = lnk_byte;
        st_nxt.nb = st_r.nb + 3'h1;
      end
    end
    if (exec) begin
      st_nxt.nb = 3'h0;
      st_nxt.ack = 1'b0;
      if (st_r.nb == 3'h0) begin
        cml = 1'b0;
      end else if (b0 == CMD_PPR) begin
        // Embedded read answers in the next frame
        if ((st_r.nb > k) && (kind != KIND_NONE) && (kind != KIND_SEND)) begin
          st_nxt.resp = rd_reg(st_r.cfg, ec, tp, st_r.page);
        end else begin
          cml = 1'b1;
        end
      end else if (!pp && (st_r.nb == 3'h1)) begin
        case (kind)
          KIND_SEND: begin
            if (ec == CMD_CLEAR) begin
              clr = 1'b1;
            end else if (ec == CMD_STORE) begin
              st_nxt.nvm = st_r.cfg;
            end else if (wr_ok(ec, st_r.cfg.guard)) begin
              st_nxt.cfg = st_r.nvm;
            end else begin
              cml = 1'b1;
            end
          end
          default: st_nxt.resp = rd_reg(st_r.cfg, ec, tp, st_r.page);
        endcase
      end else if (((kind != KIND_BYTE) && (kind != KIND_WORD)) ||
                   (st_r.nb < k + (need2 ? 3'h3 : 3'h2)) ||
                   !wr_ok(ec, st_r.cfg.guard) ||
                   ((tp >= 8'(NCH)) && (tp != ALL_PAGES) &&
                    (ec != CMD_PAGE))) begin
        cml = 1'b1; // Unknown, short, guarded or read-only
      end else if (ec == CMD_PAGE) begin
        if ((w[7:0] < 8'(NCH)) || (w[7:0] == ALL_PAGES)) begin
          st_nxt.page = w[7:0];
        end else begin
          cml = 1'b1;
        end
      end else begin
        st_nxt.cfg = wr_reg(st_r.cfg, ec, tp, w);
      end
    end
    set_v[FLT_CML_BIT] = cml;
    // A fault arriving with the clear still sets its flag
    st_nxt.flags = (clr ? 8'h00 : st_r.flags) | set_v;
    for (int i = 0; i < NCH; i++) begin
      st_nxt.run[i] = st_r.cfg.oper[i][RUN_BIT];
    end
  end

  // Core state register; the stored image powers up with the defaults
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '{cfg: CFG_RST, nvm: CFG_RST, page: PAGE_RST,
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign run_cmd_out = st_r.run;
  assign fault_flags_out = st_r.flags;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_plain_write(logic [7:0] c);
    exec && (st_r.fb[0] == c) && (st_r.nb == 3'h2) &&
    (st_r.cfg.guard == 8'h00);
  endsequence

  sequence s_send(logic [7:0] c);
    exec && (st_r.nb == 3'h1) && (st_r.fb[0] == c);
  endsequence

  AST_PAGE_SELECT: assert property (
    (exec && st_r.nb == 3'h2 && st_r.fb[0] == CMD_PAGE &&
     st_r.fb[1] == 8'h01 && !st_r.cfg.guard[GUARD_ALL_BIT])
    |=> st_r.page == 8'h01)
    else $error("page select not taken");

  AST_RUN_FOLLOWS: assert property (
    (s_plain_write(CMD_OPER) ##0 (st_r.page == 8'h00))
    |-> ##2 run_cmd_out[0] == $past(st_r.fb[1][RUN_BIT], 2))
    else $error("run output does not follow operation byte");

  AST_CLEAR_FLAGS: assert property (
    s_send(CMD_CLEAR) |=> (st_r.flags[7:4] == 4'h0) &&
      (st_r.flags[3:0] == $past({sync_q[5:4], sync_q[3:2]})))
    else $error("fault flags not cleared");

  AST_GUARD_BLOCKS: assert property (
    (exec && st_r.cfg.guard[GUARD_ALL_BIT] && st_r.fb[0] == CMD_OCLIM &&
     st_r.nb >= 3'h2)
    |=> $stable(st_r.cfg) && st_r.flags[FLT_CML_BIT])
    else $error("guarded write changed settings");

  AST_STORE_IMAGE: assert property (
    s_send(CMD_STORE) |=> st_r.nvm == $past(st_r.cfg))
    else $error("store did not copy settings");

  AST_RESTORE_IMAGE: assert property (
    (s_send(CMD_RESTORE) ##0 (st_r.cfg.guard == 8'h00))
    |=> st_r.cfg == $past(st_r.nvm))
    else $error("restore did not reload settings");

  AST_FEATURE_READ: assert property (
    s_send(CMD_FEAT) |=> st_r.resp == 16'h00B0)
    else $error("feature summary wrong");

  AST_OVR_READONLY: assert property (
    (exec && st_r.nb == 3'h2 && st_r.fb[0] == CMD_OVR)
    |=> st_r.flags[FLT_CML_BIT] ##0 $stable(st_r.cfg))
    else $error("read-only reaction accepted a write");

  AST_PAGE_PLUS_WRITE: assert property (
    (exec && st_r.nb == 3'h6 && st_r.fb[0] == CMD_PPW &&
     st_r.fb[2] == 8'h01 && st_r.fb[3] == CMD_OCLIM &&
     st_r.cfg.guard == 8'h00)
    |=> st_r.cfg.oclim[1] == {$past(st_r.fb[5]), $past(st_r.fb[4])} &&
        $stable(st_r.cfg.oclim[0]))
    else $error("page-plus write missed its page");

endmodule // pmcb_bank

// File: hw/pmcb_pkg.sv
// Purpose: Shared constants and types of the power manager command bank
// Assumes: Two output channels; link carries whole bytes only
// Notes: Linear words keep exponent in the top five bits, mantissa below

package pmcb_pkg;

  // Channel count and page selection
  localparam int NCH = 2;
  localparam logic [7:0] ALL_PAGES = 8'hFF;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // Command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPER = 8'h01;
  localparam logic [7:0] CMD_ONOFF = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_PPW = 8'h05;
  localparam logic [7:0] CMD_PPR = 8'h06;
  localparam logic [7:0] CMD_GUARD = 8'h10;
  localparam logic [7:0] CMD_STORE = 8'h15;
  localparam logic [7:0] CMD_RESTORE = 8'h16;
  localparam logic [7:0] CMD_FEAT = 8'h19;
  localparam logic [7:0] CMD_AMASK = 8'h1B;
  localparam logic [7:0] CMD_SLEW = 8'h27;
  localparam logic [7:0] CMD_FSW = 8'h33;
  localparam logic [7:0] CMD_VINON = 8'h35;
  localparam logic [7:0] CMD_VINOFF = 8'h36;
  localparam logic [7:0] CMD_GAIN = 8'h38;
  localparam logic [7:0] CMD_OVR = 8'h41;
  localparam logic [7:0] CMD_UVR = 8'h45;
  localparam logic [7:0] CMD_OCLIM = 8'h46;
  localparam logic [7:0] CMD_OCR = 8'h47;
  localparam logic [7:0] CMD_OCWARN = 8'h4A;
  localparam logic [7:0] CMD_OTLIM = 8'h4F;
  localparam logic [7:0] CMD_OTR = 8'h50;
  localparam logic [7:0] CMD_OTWARN = 8'h51;

  // Command kinds
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_BYTE = 3'h1;
  localparam logic [2:0] KIND_WORD = 3'h2;
  localparam logic [2:0] KIND_SEND = 3'h3;
  localparam logic [2:0] KIND_ROB = 3'h4;

  // Frame layout: page-plus frames carry code, count, page ahead
  localparam logic [2:0] PP_HDR = 3'h3;
  localparam logic [2:0] PP_PAGE_IDX = 3'h2;
  localparam logic [2:0] MAX_BYTES = 3'h6;

  // Guard bits and fault flag positions
  localparam int GUARD_ALL_BIT = 7;
  localparam int GUARD_OPS_BIT = 6;
  localparam int GUARD_CFG_BIT = 5;
  localparam int FLT_OC_LSB = 0;
  localparam int FLT_OT_LSB = 2;
  localparam int FLT_CML_BIT = 7;
  localparam int RUN_BIT = 7;
  localparam int LIN_EXP_LSB = 11;

  // Reset values and fixed read values
  localparam logic [7:0] OPER_RST = 8'h80;
  localparam logic [7:0] ONOFF_RST = 8'h1E;
  localparam logic [7:0] GUARD_RST = 8'h00;
  localparam logic [7:0] FEAT_VAL = 8'hB0;
  localparam logic [7:0] AMASK_RST = 8'h00;
  localparam logic [15:0] SLEW_RST = 16'hAA00;
  localparam logic [15:0] FSW_RST = 16'hFBE8;
  localparam logic [15:0] VINON_RST = 16'hCB40;
  localparam logic [15:0] VINOFF_RST = 16'hCB00;
  localparam logic [15:0] GAIN_RST = 16'hCA80;
  localparam logic [7:0] OVR_VAL = 8'h80;
  localparam logic [7:0] UVR_RST = 8'hB8;
  localparam logic [15:0] OCLIM_RST = 16'hDBB8;
  localparam logic [7:0] OCR_RST = 8'h00;
  localparam logic [15:0] OCWARN_RST = 16'hDA80;
  localparam logic [15:0] OTLIM_RST = 16'hEB20;
  localparam logic [7:0] OTR_RST = 8'hB8;
  localparam logic [15:0] OTWARN_RST = 16'hEAA8;

  // Operating configuration; the same layout serves as the stored image
  typedef struct packed {
    logic [NCH-1:0][7:0] oper;
    logic [NCH-1:0][7:0] onoff;
    logic [NCH-1:0][7:0] amask;
    logic [NCH-1:0][7:0] uvr;
    logic [NCH-1:0][7:0] ocr;
    logic [NCH-1:0][7:0] otr;
    logic [NCH-1:0][15:0] slew;
    logic [NCH-1:0][15:0] gain;
    logic [NCH-1:0][15:0] oclim;
    logic [NCH-1:0][15:0] ocwarn;
    logic [NCH-1:0][15:0] otlim;
    logic [NCH-1:0][15:0] otwarn;
    logic [7:0] guard;
    logic [15:0] fsw;
    logic [15:0] vinon;
    logic [15:0] vinoff;
  } pmcb_cfg_t;

  localparam pmcb_cfg_t CFG_RST = '{
    oper: {NCH{OPER_RST}}, onoff: {NCH{ONOFF_RST}},
    amask: {NCH{AMASK_RST}}, uvr: {NCH{UVR_RST}},
    ocr: {NCH{OCR_RST}}, otr: {NCH{OTR_RST}},
    slew: {NCH{SLEW_RST}}, gain: {NCH{GAIN_RST}},
    oclim: {NCH{OCLIM_RST}}, ocwarn: {NCH{OCWARN_RST}},
    otlim: {NCH{OTLIM_RST}}, otwarn: {NCH{OTWARN_RST}},
    guard: GUARD_RST, fsw: FSW_RST, vinon: VINON_RST, vinoff: VINOFF_RST};

endpackage

// File: hw/pmcb_sync.sv
// Purpose: Two-flop synchroniser into the core clock
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage

`timescale 1ns/1ps

module pmcb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pmcb_sync_t;

  pmcb_sync_t st_r;
  pmcb_sync_t st_nxt;

  // Shift the level through both stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.s2;

endmodule // pmcb_sync

// File: hw/pmcb_link.sv
// Purpose: Link-side shifter running on the host's link clock
// Assumes: Frame select acts as asynchronous clear between frames
// Notes: Bytes arrive MSB first; response lo byte goes out first

`timescale 1ns/1ps

module pmcb_link (
  // Link clock and frame clear
  input wire logic link_clk_in,
  input wire logic clr_n_in,
  // Serial data and response word
  input wire logic sdi_in,
  input wire logic [15:0] resp_in,
  // Byte hand-off and serial output
  output logic [7:0] byte_out,
  output logic par_out,
  output logic sdo_out
);

  typedef struct packed {
    logic [6:0] sh;
    logic [2:0] bc;
    logic [4:0] pos;
    logic [7:0] byt;
    logic par;
    logic sdo;
  } pmcb_link_t;

  pmcb_link_t st_r;
  pmcb_link_t st_nxt;

  // Collect bits; flip parity per byte so the core sees one event each
  always_comb begin
    st_nxt = st_r;
    st_nxt.sh = {st_r.sh[5:0], sdi_in};
    st_nxt.bc = st_r.bc + 3'h1;
    if (st_r.bc == 3'h7) begin
      st_nxt.byt = {st_r.sh, sdi_in};
      st_nxt.par = ~st_r.par;
    end
    // Response word is held still by the core for the whole frame
    st_nxt.sdo = st_r.pos[4] ? 1'b0 : resp_in[{st_r.pos[3], ~st_r.pos[2:0]}];
    if (!st_r.pos[4]) begin
      st_nxt.pos = st_r.pos + 5'h01;
    end
  end

  always_ff @(posedge link_clk_in or negedge clr_n_in) begin
    if (!clr_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign byte_out = st_r.byt;
  assign par_out = st_r.par;
  assign sdo_out = st_r.sdo;

endmodule // pmcb_link

// File: tb/pmcb_host.sv
// Purpose: Host model driving the byte-framed serial link
// Assumes: Link clock runs only inside frames, 48 ns period
// Notes: Data line shows the inverse of its last bit between frames

`timescale 1ns/1ps

module pmcb_host (
  // Link toward the bank
  output logic link_clk_out,
  output logic link_sel_out,
  output logic link_sdi_out,
  // Response from the bank
  input wire logic link_sdo_in
);
  // Idle link: clock parked low, no frame
  initial begin
    link_clk_out = 1'b0;
    link_sel_out = 1'b0;
    link_sdi_out = 1'b0;
  end

  // Frame of n whole bytes, first byte in the top bits of f
  task automatic xfer(input logic [47:0] f, input int n,
                      output logic [15:0] r);
    int j;
    r = 16'h0000;
    link_sel_out = 1'b1;
    #30;
    for (j = 0; j < 8 * n; j++) begin
      link_sdi_out = f[47 - j];
      #24 link_clk_out = 1'b1;
      #24;
      // Sample at the falling edge, where the response bit stands
      if (j < 8) r[7 - j] = link_sdo_in;
      else if (j < 16) r[23 - j] = link_sdo_in;
      link_clk_out = 1'b0;
    end
    // A released line must not look like a held value
    link_sdi_out = ~link_sdi_out;
    #150 link_sel_out = 1'b0;
    #300; // Gap also covers the core's command latency
  endtask
endmodule // pmcb_host

// File: tb/pmcb_bank_bench.sv
// Purpose: Self-checking bench of the power manager command bank
// Assumes: Reads answer in the frame that follows them
// Notes: mv holds expected settings per channel and code

`timescale 1ns/1ps

`define CHK(g, e) chk(16'(g), 16'(e))

module pmcb_bank_bench
  import pmcb_pkg::*;
;
  logic clock_in, nrst_in, link_clk, link_sel, link_sdi, link_sdo;
  logic [NCH-1:0] fault_oc, fault_ot, run_cmd;
  logic [7:0] flags, pg;
  logic [15:0] r, v;
  int err_total, n_tests, t, k;
  int cyc = 0;
  int mv[2][256];
  int sv[2][256];
  logic [7:0] cl[19] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h19, 8'h1B,
    8'h27, 8'h33, 8'h35, 8'h36, 8'h38, 8'h41, 8'h45, 8'h46, 8'h47,
    8'h4A, 8'h4F, 8'h50, 8'h51};
  int rv[19] = '{'h00, 'h80, 'h1E, 'h00, 'hB0, 'h00, 'hAA00, 'hFBE8,
    'hCB40, 'hCB00, 'hCA80, 'h80, 'hB8, 'hDBB8, 'h00, 'hDA80, 'hEB20,
    'hB8, 'hEAA8};

  pmcb_bank i_pmcb_bank (.clock_in(clock_in), .nrst_in(nrst_in),
    .link_clk_in(link_clk), .link_sel_in(link_sel),
    .link_sdi_in(link_sdi), .link_sdo_out(link_sdo),
    .fault_oc_in(fault_oc), .fault_ot_in(fault_ot),
    .run_cmd_out(run_cmd), .fault_flags_out(flags));
  pmcb_host i_pmcb_host (.link_clk_out(link_clk), .link_sel_out(link_sel),
    .link_sdi_out(link_sdi), .link_sdo_in(link_sdo));

  // Core clock, 25 ns
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  function automatic bit isw(logic [7:0] c);
    return c inside {8'h27, 8'h33, 8'h35, 8'h36, 8'h38, 8'h46, 8'h4A,
      8'h4F, 8'h51};
  endfunction

  // Non-paged codes share one copy, kept under channel 0
  function automatic int ix(logic [7:0] c);
    return (c inside {8'h00, 8'h10, 8'h19, 8'h33, 8'h35, 8'h36}) ? 0
      : int'(pg);
  endfunction

  function automatic real lin(logic [15:0] w);
    return $itor($signed(w[10:0])) * (2.0 ** $signed(w[15:11]));
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Words go low byte first
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] x;
    i_pmcb_host.xfer({c, d[7:0], d[15:8], 24'h0}, isw(c) ? 3 : 2, x);
  endtask

  task automatic mwr(input logic [7:0] c, input logic [15:0] d);
    wr(c, d);
    mv[ix(c)][c] = isw(c) ? d : d[7:0];
  endtask

  // Second frame rewrites the same page and carries the answer
  task automatic rd(input logic [7:0] c, output logic [15:0] q);
    logic [15:0] x;
    i_pmcb_host.xfer({c, 40'h0}, 1, x);
    i_pmcb_host.xfer({CMD_PAGE, pg, 32'h0}, 2, q);
  endtask

  task automatic setpg(input logic [7:0] p);
    wr(CMD_PAGE, {8'h00, p});
    pg = p;
    mv[0][0] = p;
  endtask

  task automatic send(input logic [7:0] c);
    logic [15:0] x;
    i_pmcb_host.xfer({c, 40'h0}, 1, x);
  endtask

  task automatic all_chk();
    int p;
    for (p = 1; p >= 0; p--) begin
      setpg(8'(p));
      for (k = 0; k < 19; k++) begin
        rd(cl[k], r);
        `CHK(r, mv[ix(cl[k])][cl[k]]);
      end
    end
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    nrst_in = 1'b0;
    fault_oc = '0;
    fault_ot = '0;
    pg = 8'h00;
    err_total = 0;
    n_tests = 0;
    for (k = 0; k < 19; k++) begin
      mv[0][cl[k]] = rv[k];
      mv[1][cl[k]] = rv[k];
    end
    void'($urandom(32'h6CA4));
    repeat (12) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    `CHK(run_cmd, 2'b11);
    all_chk();
    rd(CMD_OCLIM, r);
    `CHK(int'(lin(r) * 4.0), 119);
    // Random legal writes on random pages
    for (t = 0; t < 14; t++) begin
      setpg(8'($urandom_range(1)));
      k = $urandom_range(18);
      if (!(cl[k] inside {8'h00, 8'h10, 8'h19, 8'h41}))
        mwr(cl[k], 16'($urandom));
    end
    setpg(8'h01);
    mwr(CMD_OPER, 16'h0000);
    all_chk();
    @(negedge clock_in);
    `CHK(run_cmd, {mv[1][1][7], mv[0][1][7]});
    // Direct page access while page 0 stays selected
    setpg(8'h00);
    v = 16'($urandom);
    i_pmcb_host.xfer({CMD_PPW, 8'h04, 8'h01, CMD_OCLIM, v[7:0], v[15:8]},
      6, r);
    mv[1][8'h46] = v;
    i_pmcb_host.xfer({CMD_PPR, 8'h02, 8'h01, CMD_OCLIM, 16'h0}, 4, r);
    i_pmcb_host.xfer({CMD_PAGE, pg, 32'h0}, 2, r);
    `CHK(r, v);
    rd(CMD_OCLIM, r);
    `CHK(r, mv[0][8'h46]);
    // Write to a read-only code, then fault pins, then clear
    wr(CMD_FEAT, 16'h0055);
    rd(CMD_FEAT, r);
    `CHK(r, 16'h00B0);
    wr(CMD_OVR, 16'h0011);
    rd(CMD_OVR, r);
    `CHK(r, 16'h0080);
    fault_oc <= 2'b10;
    fault_ot <= 2'b01;
    repeat (8) @(posedge clock_in);
    fault_oc <= 2'b00;
    fault_ot <= 2'b00;
    repeat (8) @(negedge clock_in);
    `CHK(flags, 8'h86);
    send(CMD_CLEAR);
    @(negedge clock_in);
    `CHK(flags, 8'h00);
    // Guard blocks an ordinary write
    mwr(CMD_GUARD, 16'h0080);
    wr(CMD_OCLIM, 16'(~mv[0][8'h46]));
    rd(CMD_OCLIM, r);
    `CHK(r, mv[0][8'h46]);
    mwr(CMD_GUARD, 16'h0000);
    @(negedge clock_in);
    `CHK(flags, 8'h80);
    send(CMD_CLEAR);
    // Store, disturb, restore
    mwr(CMD_OCLIM, 16'($urandom));
    send(CMD_STORE);
    sv = mv;
    mwr(CMD_OCWARN, 16'($urandom));
    mwr(CMD_OPER, 16'h0000);
    send(CMD_RESTORE);
    mv = sv;
    all_chk();
    print_verdict();
  end
endmodule // pmcb_bank_bench
